// >>> design/mcj_top.sv
// Conditional jump unit of a microcore with its APB register file.
//
// Operation
// - Taken ALU-flag absolute jump loads PC from the chosen jump register.
// - Jump register operand picks one of the set; any code address allowed.
// - Absolute ALU jump: opcode 15:9, flag select 8:5, reg 4, tail 0101.
// - ALU jump conditions come from the ALU condition register.
// - Codes 0000-0100: done, signed over/under, unsigned over/under.
// - Codes 0101-1010: sign, zero, mul loss, mul over, mask ones/zeros.
// - Codes 1011-1111: aux A0, aux A1, carry, conversion sign, shift carry.
// - Taken relative jump adds offset to the jump's own code address.
// - Offset is five-bit two's complement, reach -16 to 15.
// - Relative ALU jump: opcode 15:9, flag select 8:5, offset 4:0.
// - Control-bit jump loads PC from jump register when bit matches level.
// - Bit selector n picks bit n of the 16-bit control word.
// - Level 0 is true on a zero bit, level 1 on a one bit.
// - Control-bit jump reads the control word of its own microcore; here the configuration's core and channel bits pick one of four words.
// - Control jump: opcode 15:10, level 9, select 8:5, reg 4, tail 0100.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "mcj_map.svh"
module mcj_top #(
  parameter int ADDR_W  = 10,
  parameter int PADDR_W = 12
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [15:0]        alu_cond,
  output logic      [ADDR_W-1:0]  fetch_addr,
  input  wire logic               instr_valid,
  input  wire logic [15:0]        instr_word,
  output logic                    instr_ready,
  output logic                    jump_taken,
  output mcj_pkg::mcj_kind_e      exec_kind
);
  import mcj_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations.

  // One control word per microcore and channel.
  localparam int N_CTRL = 4;

  mcj_dec_if dif ();

  mcj_state_e          state_q;
  logic [ADDR_W-1:0]   pc_q;
  logic [15:0]         instr_q;
  logic [15:0]         ctrl_q [N_CTRL];
  logic [ADDR_W-1:0]   jump0_q;
  logic [ADDR_W-1:0]   jump1_q;
  logic [ADDR_W-1:0]   entry_q;
  logic [2:0]          cfg_q;
  logic                last_taken_q;
  mcj_kind_e           last_kind_q;
  logic [15:0]         taken_cnt_q;
  logic [31:0]         prdata_q;
  logic                jump_taken_q;
  mcj_kind_e           exec_kind_q;

  logic [PADDR_W-3:0]  idx;
  logic                aligned;
  logic                hit;
  logic                wr_acc;
  logic                setup;
  logic [31:0]         rd_d;
  logic [1:0]          core_sel;
  logic                do_exec;
  logic                taken;
  logic [ADDR_W-1:0]   abs_target;
  logic [ADDR_W-1:0]   rel_target;
  logic [ADDR_W-1:0]   pc_d;
  logic [ADDR_W-1:0]   ofs_ext;

  ////////////////////////////////////////////////////////////////////////
  // Decoder and condition selector.

  mcj_decode u_decode (
    .d (dif.dec)
  );

  mcj_cond u_cond (
    .c (dif.cnd)
  );

  assign dif.instr     = instr_q;
  assign dif.alu_flags = alu_cond;

  // The control word of the microcore chosen by the configuration.
  assign core_sel      = {cfg_q[`MCJ_CFG_CHAN], cfg_q[`MCJ_CFG_CORE]};
  assign dif.ctrl_word = ctrl_q[core_sel];

  ////////////////////////////////////////////////////////////////////////
  // APB decode. The slave answers without wait states, so pready is a
  // constant; a master that inserts idle cycles between transfers is
  // served the same way. Writes to the read-only status and counter
  // words are dropped without an error; only unmapped or unaligned
  // addresses raise pslverr.

  assign idx     = paddr[PADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite && hit;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Address hit and read mux; read data is latched in the setup cycle so
  // the access phase drives it straight from a flip-flop.
  always_comb begin
    hit  = aligned;
    rd_d = 32'h0000_0000;
    unique case (idx)
      `MCJ_IDX_CONFIG:      rd_d = {29'h0, cfg_q};
      `MCJ_IDX_CORE0_CTRL:  rd_d = {16'h0, ctrl_q[0]};
      `MCJ_IDX_CORE1_CTRL:  rd_d = {16'h0, ctrl_q[1]};
      `MCJ_IDX_CORE0_CTRL2: rd_d = {16'h0, ctrl_q[2]};
      `MCJ_IDX_CORE1_CTRL2: rd_d = {16'h0, ctrl_q[3]};
      `MCJ_IDX_ENTRY:       rd_d = 32'(entry_q);
      `MCJ_IDX_JUMP0:       rd_d = 32'(jump0_q);
      `MCJ_IDX_JUMP1:       rd_d = 32'(jump1_q);
      `MCJ_IDX_TAKEN_CNT:   rd_d = {16'h0, taken_cnt_q};
      `MCJ_IDX_STATUS: begin
        rd_d = 32'(pc_q);
        rd_d[`MCJ_ST_TAKEN] = last_taken_q;
        rd_d[`MCJ_ST_KIND_LSB +: 2] = last_kind_q;
        rd_d[`MCJ_ST_STATE_LSB +: 2] = state_q;
      end
      default: hit = 1'b0;
    endcase
    if (!aligned) begin
      rd_d = 32'h0000_0000;
    end
  end

  // Read data register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= rd_d;
    end
  end

  assign prdata = prdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Software registers.

  // Configuration: run enable and which microcore's control word is read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `MCJ_RST_CFG;
    end else if (wr_acc && idx == `MCJ_IDX_CONFIG) begin
      cfg_q <= pwdata[2:0];
    end
  end

  // The four control words, one per microcore and channel.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N_CTRL; i++) begin
        ctrl_q[i] <= `MCJ_RST_CTRL;
      end
    end else if (wr_acc) begin
      unique case (idx)
        `MCJ_IDX_CORE0_CTRL:  ctrl_q[0] <= pwdata[15:0];
        `MCJ_IDX_CORE1_CTRL:  ctrl_q[1] <= pwdata[15:0];
        `MCJ_IDX_CORE0_CTRL2: ctrl_q[2] <= pwdata[15:0];
        `MCJ_IDX_CORE1_CTRL2: ctrl_q[3] <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Jump register set and entry point; full code-space width is kept so
  // any location can be a target.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jump0_q <= '0;
      jump1_q <= '0;
      entry_q <= '0;
    end else if (wr_acc) begin
      unique case (idx)
        `MCJ_IDX_JUMP0: jump0_q <= pwdata[ADDR_W-1:0];
        `MCJ_IDX_JUMP1: jump1_q <= pwdata[ADDR_W-1:0];
        `MCJ_IDX_ENTRY: entry_q <= pwdata[ADDR_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fetch and execute sequencing.

  assign instr_ready = (state_q == MCJ_ST_FETCH);
  assign fetch_addr  = pc_q;
  assign do_exec     = (state_q == MCJ_ST_EXEC);

  // Sequencer: halted until run is set, then fetch and execute in turn.
  // Clearing run drops out at once; an instruction in execute still finishes, a word fetched on that edge is lost.
  // Leaving halt costs one cycle, so the entry point is in the program
  // counter before the first fetch is offered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= MCJ_ST_HALT;
    end else if (!cfg_q[`MCJ_CFG_RUN]) begin
      state_q <= MCJ_ST_HALT;
    end else begin
      unique case (state_q)
        MCJ_ST_HALT:  state_q <= MCJ_ST_FETCH;
        MCJ_ST_FETCH: if (instr_valid) begin
          state_q <= MCJ_ST_EXEC;
        end
        MCJ_ST_EXEC:  state_q <= MCJ_ST_FETCH;
        default:      state_q <= MCJ_ST_HALT;
      endcase
    end
  end

  // Instruction latch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q <= 16'h0000;
    end else if (instr_ready && instr_valid) begin
      instr_q <= instr_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Target address and program counter.

  // Sign-extended offset; the sum wraps within the code space.
  assign ofs_ext    = {{(ADDR_W-5){dif.offset[4]}}, dif.offset};
  assign rel_target = pc_q + ofs_ext;
  assign abs_target = dif.jreg ? jump1_q : jump0_q;
  assign taken      = (dif.kind != MCJ_KIND_NONE) && dif.cond_true;

  // Next program counter for the instruction in execute. The counter
  // still holds the jump's own address during execute, which is the
  // base that a relative jump needs.
  always_comb begin
    pc_d = pc_q + 1'b1;
    if (taken) begin
      unique case (dif.kind)
        MCJ_KIND_ABS_ALU:  pc_d = abs_target;
        MCJ_KIND_ABS_CTRL: pc_d = abs_target;
        MCJ_KIND_REL_ALU:  pc_d = rel_target;
        MCJ_KIND_NONE:     pc_d = pc_q + 1'b1;
      endcase
    end
  end

  // Program counter: parked at the entry point while halted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= '0;
    end else if (state_q == MCJ_ST_HALT) begin
      pc_q <= entry_q;
    end else if (do_exec) begin
      pc_q <= pc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Execution report and statistics.

  // One-cycle report of each executed instruction.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jump_taken_q <= 1'b0;
      exec_kind_q  <= MCJ_KIND_NONE;
    end else begin
      jump_taken_q <= do_exec && taken;
      exec_kind_q  <= do_exec ? dif.kind : MCJ_KIND_NONE;
    end
  end

  assign jump_taken = jump_taken_q;
  assign exec_kind  = exec_kind_q;

  // Outcome of the last jump instruction; untaken jumps leave the counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_taken_q <= 1'b0;
      last_kind_q  <= MCJ_KIND_NONE;
      taken_cnt_q  <= 16'h0000;
    end else if (do_exec && dif.kind != MCJ_KIND_NONE) begin
      last_taken_q <= taken;
      last_kind_q  <= dif.kind;
      if (taken) begin
        taken_cnt_q <= taken_cnt_q + 16'h0001;
      end
    end
  end
endmodule

// >>> design/mcj_map.svh
// Register indices, instruction field positions and reset values.
`ifndef MCJ_MAP_SVH
`define MCJ_MAP_SVH

// Register indices; the byte address is four times the index.
`define MCJ_IDX_CONFIG      10'h100
`define MCJ_IDX_CORE0_CTRL  10'h101
`define MCJ_IDX_CORE1_CTRL  10'h102
`define MCJ_IDX_ENTRY       10'h103
`define MCJ_IDX_STATUS      10'h104
`define MCJ_IDX_TAKEN_CNT   10'h105
`define MCJ_IDX_JUMP0       10'h110
`define MCJ_IDX_JUMP1       10'h111
`define MCJ_IDX_CORE0_CTRL2 10'h121
`define MCJ_IDX_CORE1_CTRL2 10'h122

// Configuration register bits.
`define MCJ_CFG_RUN         0
`define MCJ_CFG_CORE        1
`define MCJ_CFG_CHAN        2

// Status register field positions.
`define MCJ_ST_TAKEN        16
`define MCJ_ST_KIND_LSB     17
`define MCJ_ST_STATE_LSB    19

// Reset values.
`define MCJ_RST_CTRL        16'h0000
`define MCJ_RST_CFG         3'h0

// Instruction opcodes and fixed patterns.
`define MCJ_OPC_ABS_ALU     7'h1D
`define MCJ_OPC_REL_ALU     7'h12
`define MCJ_OPC_ABS_CTRL    6'h0F
`define MCJ_PAT_ABS_ALU     4'h5
`define MCJ_PAT_ABS_CTRL    4'h4

// Instruction field positions.
`define MCJ_F_OPC7_MSB      15
`define MCJ_F_OPC7_LSB      9
`define MCJ_F_OPC6_LSB      10
`define MCJ_F_LEVEL         9
`define MCJ_F_SEL_MSB       8
`define MCJ_F_SEL_LSB       5
`define MCJ_F_JREG          4
`define MCJ_F_PAT_MSB       3
`define MCJ_F_OFS_MSB       4

`endif

// >>> design/mcj_pkg.sv
// Types shared by the conditional jump unit.
package mcj_pkg;
  typedef enum logic [1:0] {
    MCJ_KIND_NONE     = 2'h0,
    MCJ_KIND_ABS_ALU  = 2'h1,
    MCJ_KIND_REL_ALU  = 2'h2,
    MCJ_KIND_ABS_CTRL = 2'h3
  } mcj_kind_e;

  typedef enum logic [1:0] {
    MCJ_ST_HALT  = 2'h0,
    MCJ_ST_FETCH = 2'h1,
    MCJ_ST_EXEC  = 2'h3
  } mcj_state_e;
endpackage

// >>> design/mcj_dec_if.sv
// Interface joining the core, the decoder and the condition selector.
`timescale 1ns/1ps
interface mcj_dec_if;
  import mcj_pkg::*;
  logic [15:0] instr;
  logic [15:0] alu_flags;
  logic [15:0] ctrl_word;
  mcj_kind_e   kind;
  logic [3:0]  sel;
  logic        jreg;
  logic        level;
  logic [4:0]  offset;
  logic        cond_true;

  modport dec  (input instr, output kind, sel, jreg, level, offset);
  modport cnd  (input kind, sel, level, alu_flags, ctrl_word,
                output cond_true);
  modport core (output instr, alu_flags, ctrl_word,
                input kind, jreg, offset, cond_true);
endinterface

// >>> design/mcj_decode.sv
// Decoder for the three conditional jump instruction words.
`timescale 1ns/1ps
`include "mcj_map.svh"
module mcj_decode (
  mcj_dec_if.dec d
);
  import mcj_pkg::*;

  // Opcode and fixed-pattern match; anything else is not a jump here.
  always_comb begin
    d.kind = MCJ_KIND_NONE;
    if (d.instr[`MCJ_F_OPC7_MSB:`MCJ_F_OPC7_LSB] == `MCJ_OPC_ABS_ALU &&
        d.instr[`MCJ_F_PAT_MSB:0] == `MCJ_PAT_ABS_ALU) begin
      d.kind = MCJ_KIND_ABS_ALU;
    end else if (d.instr[`MCJ_F_OPC7_MSB:`MCJ_F_OPC7_LSB] ==
                 `MCJ_OPC_REL_ALU) begin
      d.kind = MCJ_KIND_REL_ALU;
    end else if (d.instr[`MCJ_F_OPC7_MSB:`MCJ_F_OPC6_LSB] ==
                 `MCJ_OPC_ABS_CTRL &&
                 d.instr[`MCJ_F_PAT_MSB:0] == `MCJ_PAT_ABS_CTRL) begin
      d.kind = MCJ_KIND_ABS_CTRL;
    end
  end

  // Operand fields sit at the same place in all three words.
  assign d.sel    = d.instr[`MCJ_F_SEL_MSB:`MCJ_F_SEL_LSB];
  assign d.jreg   = d.instr[`MCJ_F_JREG];
  assign d.level  = d.instr[`MCJ_F_LEVEL];
  assign d.offset = d.instr[`MCJ_F_OFS_MSB:0];
endmodule

// >>> design/mcj_cond.sv
// Jump condition selector over ALU flags and the control word.
`timescale 1ns/1ps
module mcj_cond (
  mcj_dec_if.cnd c
);
  import mcj_pkg::*;

  // Flag code n reads ALU condition bit n, so the mapping lives in the
  // ALU's packing of its condition register.
  logic alu_bit;
  logic ctrl_bit;

  assign alu_bit  = c.alu_flags[c.sel];
  assign ctrl_bit = c.ctrl_word[c.sel];

  // Control-bit jumps compare against the requested level.
  always_comb begin
    c.cond_true = 1'b0;
    unique case (c.kind)
      MCJ_KIND_ABS_ALU:  c.cond_true = alu_bit;
      MCJ_KIND_REL_ALU:  c.cond_true = alu_bit;
      MCJ_KIND_ABS_CTRL: c.cond_true = (ctrl_bit == c.level);
      MCJ_KIND_NONE:     c.cond_true = 1'b0;
    endcase
  end
endmodule

// >>> bench/mcj_top_sva.sv
// Checker for the ports of the conditional jump unit.
`timescale 1ns/1ps
module mcj_top_sva
  import mcj_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic [15:0]        alu_cond,
  input wire logic [ADDR_W-1:0]  fetch_addr,
  input wire logic               instr_valid,
  input wire logic [15:0]        instr_word,
  input wire logic               instr_ready,
  input wire logic               jump_taken,
  input wire mcj_pkg::mcj_kind_e exec_kind
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic              hs, ex_q, a_alu, r_alu, a_ctl, f;
  logic [15:0]       w_q;
  logic [ADDR_W-1:0] pc_q, rel_tgt;

  // Decode the mirrored word with literal field values, not the design's.
  assign hs = instr_ready && instr_valid;
  assign a_alu = w_q[15:9] == 7'h1D && w_q[3:0] == 4'h5;
  assign r_alu = w_q[15:9] == 7'h12;
  assign a_ctl = w_q[15:10] == 6'h0F && w_q[3:0] == 4'h4;
  assign f = alu_cond[w_q[8:5]];
  // The sum wraps at the counter width, as the code space does.
  assign rel_tgt = pc_q + {{(ADDR_W-5){w_q[4]}}, w_q[4:0]};

  // Keep each accepted word and its address for the execute cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ex_q <= 1'b0;
      w_q  <= 16'h0000;
      pc_q <= '0;
    end else begin
      ex_q <= hs;
      if (hs) begin
        w_q  <= instr_word;
        pc_q <= fetch_addr;
      end
    end
  end

  ////////////////////////////////////////
  sequence s_alu_exec;
    ex_q && (a_alu || r_alu);
  endsequence
  sequence s_ctl_exec;
    ex_q && a_ctl;
  endsequence

  chk_abs_kind: assert property (
    ex_q && a_alu |=> exec_kind == MCJ_KIND_ABS_ALU)
    else $error("absolute flag jump kind missing");
  chk_rel_kind: assert property (
    ex_q && r_alu |=> exec_kind == MCJ_KIND_REL_ALU)
    else $error("relative flag jump kind missing");
  chk_ctl_kind: assert property (
    s_ctl_exec |=> exec_kind == MCJ_KIND_ABS_CTRL)
    else $error("control bit jump kind missing");
  chk_alu_taken: assert property (
    s_alu_exec |=> jump_taken == $past(f))
    else $error("taken flag disagrees with selected flag");
  chk_rel_target: assert property (
    ex_q && r_alu && f |=> fetch_addr == rel_tgt)
    else $error("relative target wrong");
  chk_alu_untaken: assert property (
    s_alu_exec ##0 !f |=> fetch_addr == pc_q + 1'b1)
    else $error("untaken flag jump did not step");
  chk_ctl_untaken: assert property (
    s_ctl_exec |=> jump_taken || fetch_addr == pc_q + 1'b1)
    else $error("untaken control jump did not step");
  chk_taken_pulse: assert property (
    jump_taken |-> exec_kind != MCJ_KIND_NONE ##1 !jump_taken)
    else $error("taken pulse without a jump");
endmodule

bind mcj_top mcj_top_sva #(.ADDR_W(ADDR_W)) chk (
  .pclk(pclk), .presetn(presetn), .alu_cond(alu_cond),
  .fetch_addr(fetch_addr), .instr_valid(instr_valid),
  .instr_word(instr_word), .instr_ready(instr_ready),
  .jump_taken(jump_taken), .exec_kind(exec_kind));

// >>> bench/mcj_code_model.sv
// Code memory model feeding instruction words to the jump unit.
`timescale 1ns/1ps
module mcj_code_model #(
  parameter int ADDR_W = 10
) (
  input  wire logic              pclk,
  input  wire logic              slow,
  input  wire logic              instr_ready,
  input  wire logic [ADDR_W-1:0] fetch_addr,
  output logic                   instr_valid,
  output logic [15:0]            instr_word
);
  logic [15:0] mem [1<<ADDR_W];
  logic        ph = 1'b0;

  // Clear code space; the bench places the words under test.
  initial foreach (mem[i]) mem[i] = 16'h0000;

  // In slow mode a word is offered only every other cycle.
  always @(posedge pclk) ph <= ~ph;

  // Outside a fetch the bus shows the inverse, never a stale word.
  assign instr_valid = instr_ready && (!slow || ph);
  assign instr_word  = instr_valid ? mem[fetch_addr] : ~mem[fetch_addr];
endmodule

// >>> bench/test_mcj_top.sv
// Self-checking bench for the conditional jump unit.
`timescale 1ns/1ps
`include "mcj_map.svh"
module test_mcj_top;
  import mcj_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, slow;
  logic        pready, pslverr, err_q, instr_valid, instr_ready, jump_taken;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [15:0] alu_cond, instr_word;
  logic [9:0]  fetch_addr;
  logic [2:0]  cfg;
  mcj_kind_e   exec_kind;
  int          err_total, checks, n_taken;

  mcj_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alu_cond(alu_cond), .fetch_addr(fetch_addr),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .jump_taken(jump_taken),
    .exec_kind(exec_kind));
  mcj_code_model code (.pclk(pclk), .slow(slow),
    .instr_ready(instr_ready), .fetch_addr(fetch_addr),
    .instr_valid(instr_valid), .instr_word(instr_word));

  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // The whole sequence needs well under a tenth of this span.
  initial begin
    #300us;
    err_total++;
    conclude();
  end

  ////////////////////////////////////////
  task automatic conclude();
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // One transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask

  task automatic rd(input string nm, input logic [9:0] i,
      input logic [31:0] e);
    apb(1'b0, {i, 2'b00}, 32'h0);
    chk(nm, rd_q, e);
  endtask

  // Run one word from a halted start and judge the following fetch.
  task automatic run_one(input logic [9:0] pc, input logic [15:0] w,
      input logic [9:0] ep, input mcj_kind_e ek, input logic et);
    int n;
    wr(`MCJ_IDX_ENTRY, {22'h0, pc});
    code.mem[pc] = w;
    wr(`MCJ_IDX_CONFIG, {29'h0, cfg | 3'h1});
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (exec_kind === MCJ_KIND_NONE && n < 40);
    chk("exec_kind", {30'h0, exec_kind}, {30'h0, ek});
    chk("jump_taken", {31'h0, jump_taken}, {31'h0, et});
    chk("fetch_addr", {22'h0, fetch_addr}, {22'h0, ep});
    n_taken += et;
    wr(`MCJ_IDX_CONFIG, {29'h0, cfg});
    code.mem[pc] = 16'h0000;
  endtask

  // Reset values, the jump register set and refused addresses.
  task automatic t_regs();
    rd("config", `MCJ_IDX_CONFIG, 32'h0);
    rd("ctrl0", `MCJ_IDX_CORE0_CTRL, 32'h0);
    wr(`MCJ_IDX_JUMP0, 32'h3FF);
    wr(`MCJ_IDX_JUMP1, 32'h155);
    apb(1'b1, 12'h445, 32'h5);
    chk("unaligned", {31'h0, err_q}, 32'h1);
    apb(1'b0, 12'h4FC, 32'h0);
    chk("unmapped", {31'h0, err_q}, 32'h1);
    rd("jump0", `MCJ_IDX_JUMP0, 32'h3FF);
    rd("jump1", `MCJ_IDX_JUMP1, 32'h155);
  endtask

  // Each flag code set alone and cleared alone, both jump registers.
  task automatic t_abs();
    for (int c = 0; c < 16; c++) begin
      alu_cond <= 16'h0001 << c;
      run_one(10'h040, {7'h1D, 4'(c), c[0], 4'h5},
              c[0] ? 10'h155 : 10'h3FF, MCJ_KIND_ABS_ALU, 1'b1);
      alu_cond <= ~(16'h0001 << c);
      run_one(10'h040, {7'h1D, 4'(c), c[0], 4'h5}, 10'h041,
              MCJ_KIND_ABS_ALU, 1'b0);
    end
  endtask

  // Offset extremes wrapping at both ends of code space, slow fetch.
  task automatic t_rel();
    slow <= 1'b1;
    alu_cond <= 16'h0040;
    run_one(10'h005, {7'h12, 4'h6, 5'h10}, 10'h3F5,
            MCJ_KIND_REL_ALU, 1'b1);
    run_one(10'h3FA, {7'h12, 4'h6, 5'h0F}, 10'h009,
            MCJ_KIND_REL_ALU, 1'b1);
    run_one(10'h100, {7'h12, 4'h5, 5'h1F}, 10'h101,
            MCJ_KIND_REL_ALU, 1'b0);
    slow <= 1'b0;
  endtask

  // Every bit at both levels, then each of the four control words.
  task automatic t_ctl();
    logic [15:0] p;
    logic        t;
    p = 16'hA5C3;
    wr(`MCJ_IDX_CORE0_CTRL, {16'h0, p});
    for (int b = 0; b < 32; b++) begin
      t = p[b[3:0]] == b[4];
      run_one(10'h080, {6'h0F, b[4], 4'(b), b[0], 4'h4},
              t ? (b[0] ? 10'h155 : 10'h3FF) : 10'h081,
              MCJ_KIND_ABS_CTRL, t);
    end
    for (int s = 0; s < 4; s++) begin
      cfg = {s[1:0], 1'b0};
      wr(`MCJ_IDX_CORE0_CTRL, {31'h0, s == 0});
      wr(`MCJ_IDX_CORE1_CTRL, {31'h0, s == 1});
      wr(`MCJ_IDX_CORE0_CTRL2, {31'h0, s == 2});
      wr(`MCJ_IDX_CORE1_CTRL2, {31'h0, s == 3});
      run_one(10'h080, 16'h3E04, 10'h3FF,
              MCJ_KIND_ABS_CTRL, 1'b1);
    end
    cfg = 3'h0;
  endtask

  // Main sequence.
  initial begin
    {psel, penable, pwrite, slow} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    alu_cond = 16'h0000;
    cfg = 3'h0;
    err_total = 0;
    checks = 0;
    n_taken = 0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_abs();
    t_rel();
    t_ctl();
    rd("taken_cnt", `MCJ_IDX_TAKEN_CNT, n_taken);
    // Halted at the last entry point after a taken control-bit jump.
    rd("status", `MCJ_IDX_STATUS, 32'h0007_0080);
    conclude();
  end
endmodule
